// File: src/fso_link_if.sv
// Purpose: Byte-level carrier between the serial shifter and the core.
// Assumes: All signals on the core clock.
// Notes:   Strobes are one-cycle pulses.
`timescale 1ns/10ps
interface fso_link_if;
  logic       byte_valid;
  logic [7:0] rx_byte;
  logic       frame_start;
  logic       frame_end;
  logic [7:0] tx_byte;
  logic       tx_en;

  modport shifter (output byte_valid, rx_byte, frame_start, frame_end,
                   input  tx_byte, tx_en);
  modport core    (input  byte_valid, rx_byte, frame_start, frame_end,
                   output tx_byte, tx_en);
endinterface : fso_link_if

// File: src/fso_pkg.sv
// Purpose: Shared constants, opcodes and types for the status one block.
// Assumes: Single-bit serial link, 3-byte register addresses.
// Notes:   Array program and erase opcodes are defaults for the engine.
package fso_pkg;

  localparam logic [7:0] OP_WRR    = 8'h01;
  localparam logic [7:0] OP_WRITE_DISABLE_CMD   = 8'h04;
  localparam logic [7:0] OP_RD_SR1 = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD   = 8'h06;
  localparam logic [7:0] OP_RD_SR2 = 8'h07;
  localparam logic [7:0] OP_CLEAR_STATUS_CMD   = 8'h30;
  localparam logic [7:0] OP_READ_CONFIG_ONE_CMD  = 8'h35;
  localparam logic [7:0] OP_READ_ANY_REGISTER_CMD   = 8'h65;
  localparam logic [7:0] OP_RESET_ARM_CMD  = 8'h66;
  localparam logic [7:0] OP_WRITE_ANY_REGISTER_CMD   = 8'h71;
  localparam logic [7:0] OP_EPS    = 8'h75;
  localparam logic [7:0] OP_RST    = 8'h99;
  localparam logic [7:0] OP_PP     = 8'h02;
  localparam logic [7:0] OP_SE     = 8'hD8;
  localparam logic [7:0] OP_P4E    = 8'h20;
  localparam logic [7:0] OP_CE     = 8'h60;

  localparam int SR1_LOCK  = 7;
  localparam int SR1_TB    = 5;
  localparam int SR1_BP_HI = 4;
  localparam int SR1_BP_LO = 2;
  localparam int SR1_WEL   = 1;
  localparam int SR1_BUSY  = 0;
  localparam int SR2_EERR  = 6;
  localparam int SR2_PERR  = 5;
  localparam int SR2_ES    = 1;

  localparam int          ADDR_BYTES = 3;
  localparam logic [23:0] ADDR_STATUS_ONE_VOLATILE  = 24'h80_0000;
  localparam logic [22:0] GROUP_SPAN = 23'h00_0006;

  typedef enum logic [2:0] {
    ST_IDLE, ST_OP, ST_ADDR, ST_DATA, ST_READ, ST_SKIP
  } fso_state_t;

  function automatic logic fso_is_erase(input logic [7:0] op);
    fso_is_erase = (op == OP_SE) || (op == OP_P4E) || (op == OP_CE);
  endfunction : fso_is_erase

  function automatic logic fso_is_array(input logic [7:0] op);
    fso_is_array = (op == OP_PP) || fso_is_erase(op);
  endfunction : fso_is_array

endpackage : fso_pkg

// File: src/fso_spi_shift.sv
// Purpose: Mode 0 serial shifter, sampled by the core clock.
// Assumes: Inputs already synchronised; serial clock well below clk/4.
// Notes:   Output bits change on the falling serial clock edge.
`timescale 1ns/10ps
module fso_spi_shift (
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   sclk_s,
  input  wire logic   cs_n_s,
  input  wire logic   si_s,
  output logic        so,
  output logic        so_oe,
  fso_link_if.shifter link
);
  logic       sclk_d_r;
  logic       cs_d_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] sh_r;
  logic [7:0] tx_sh_r;
  logic       rise;
  logic       fall;
  logic       act;

  assign rise  = sclk_s & ~sclk_d_r;
  assign fall  = ~sclk_s & sclk_d_r;
  assign act   = ~cs_n_s;
  assign so    = tx_sh_r[7];
  assign so_oe = link.tx_en & act;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sclk_d_r         <= 1'b0;
      cs_d_r           <= 1'b1;
      link.frame_start <= 1'b0;
      link.frame_end   <= 1'b0;
    end
    else
    begin
      sclk_d_r         <= sclk_s;
      cs_d_r           <= cs_n_s;
      link.frame_start <= ~cs_n_s & cs_d_r;
      link.frame_end   <= cs_n_s & ~cs_d_r;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bit_cnt_r       <= 3'h0;
      sh_r            <= 8'h00;
      link.rx_byte    <= 8'h00;
      link.byte_valid <= 1'b0;
    end
    else
    begin
      link.byte_valid <= 1'b0;
      if (!act)
        bit_cnt_r <= 3'h0;
      else if (rise)
      begin
        sh_r      <= {sh_r[6:0], si_s};
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (bit_cnt_r == 3'h7)
        begin
          link.rx_byte    <= {sh_r[6:0], si_s};
          link.byte_valid <= 1'b1;
        end
      end
    end
  end

  // Load at a byte boundary so a read answer starts with its top bit.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tx_sh_r <= 8'h00;
    else if (act && fall)
      tx_sh_r <= (bit_cnt_r == 3'h0) ? link.tx_byte : {tx_sh_r[6:0], 1'b0};
  end
endmodule : fso_spi_shift

// File: src/fso_status_one.sv
// Purpose: Volatile status register one, write latch, busy and gating.
// Assumes: Embedded engine reports op_done or op_fail once per op_start.
// Notes:   Non-volatile copies live outside and arrive on nv_status_one.
`timescale 1ns/10ps
// Notes on behaviour
// - Opcode 05h returns the eight status one bits.
// - Lock set and protect pin low: ignore writes to status/config.
// - Lock clear: protect pin ignored, registers writable.
// - Protect pin never blocks writes to other registers.
// - Lock and reference bits follow writes to their non-volatile copies.
// - Quad protocol or quad data mode forces protect pin high.
// - Reference bit: 0 protects from top, 1 from address zero.
// - Bits 4 to 2 select the array part guarded against writes.
// - Program, register write or erase starts only with latch set.
// - Write enable 06h sets the write enable latch.
// - Write disable clears the latch, blocking later modifying commands.
// - Successful completion clears the latch; failure leaves it set.
// - Any reset loads the latch from its non-volatile default.
// - Register writes leave the latch alone; enable, disable, clear alter.
// - Busy bit is 1 while an operation runs, 0 when ready.
// - While busy only status, config, any-read, suspend, clear, reset.
// - Erase suspend only taken while an array operation runs.
// - Error flags keep busy high until clear-status arrives.
// - Busy bit is read-only, untouched by register writes.
// - Any reset copies non-volatile values into volatile bits.
// - Clear-status resets erase and program error flags.
module fso_status_one
  import fso_pkg::*;
#(
  parameter logic [7:0] OP_READ_CONFIG_TWO_CMD = 8'h3F,
  parameter logic [7:0] OP_READ_CONFIG_THREE_CMD = 8'h3E
) (
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  spi_sclk,
  input  wire logic  spi_cs_n,
  input  wire logic  spi_si,
  input  wire logic  wp_n,
  output logic       spi_so,
  output logic       spi_so_oe,
  input  wire logic [7:0] nv_status_one,
  input  wire logic  nv_update,
  input  wire logic  quad_protocol_mode,
  input  wire logic  quad_data_mode,
  input  wire logic  array_op_active,
  input  wire logic  erase_suspended,
  input  wire logic  op_done,
  input  wire logic  op_fail,
  output logic       op_start,
  output logic [7:0] op_code,
  output logic       suspend_req,
  output logic       soft_reset,
  output logic [7:0] status_one_volatile,
  output logic [7:0] status_two,
  output logic       reg_locked,
  output logic [2:0] block_protect,
  output logic       protect_from_top
);
  fso_link_if link ();

  logic [2:0]  pins_s;
  logic        wp_s;
  fso_state_t  state_r;
  logic [7:0]  opc_r;
  logic [23:0] addr_r;
  logic [1:0]  addr_cnt_r;
  logic [7:0]  data_r;
  logic        have_data_r;
  logic        exec_ok_r;
  logic        load_r;
  logic        armed_r;
  logic        lock_r;
  logic        tb_r;
  logic [2:0]  bp_r;
  logic        wel_r;
  logic        running_r;
  logic        erase_op_r;
  logic        perr_r;
  logic        eerr_r;
  logic        busy;
  logic        wp_int;
  logic        exec;
  logic        in_group;
  logic        wr_ok;
  logic        write_any_register_cmd_ok;
  logic        start_ok;
  logic        busy_ok;

  fso_sync #(.W(3), .RST_VAL(3'h2)) u_pin_sync (
    .clk (clk),
    .rst (rst),
    .d   ({spi_sclk, spi_cs_n, spi_si}),
    .q   (pins_s)
  );

  fso_sync #(.W(1), .RST_VAL(1'b1)) u_wp_sync (
    .clk (clk),
    .rst (rst),
    .d   (wp_n),
    .q   (wp_s)
  );

  fso_spi_shift u_shift (
    .clk    (clk),
    .rst    (rst),
    .sclk_s (pins_s[2]),
    .cs_n_s (pins_s[1]),
    .si_s   (pins_s[0]),
    .so     (spi_so),
    .so_oe  (spi_so_oe),
    .link   (link)
  );

  // In quad modes the protect pin carries data, so it cannot lock.
  assign wp_int     = wp_s | quad_protocol_mode | quad_data_mode;
  assign reg_locked = lock_r & ~wp_int;
  assign busy       = running_r | perr_r | eerr_r;
  assign exec       = link.frame_end & exec_ok_r;
  assign in_group   = addr_r[22:0] < GROUP_SPAN;
  assign wr_ok      = wel_r & ~reg_locked & have_data_r;
  assign write_any_register_cmd_ok    = wel_r & have_data_r
                      & (~reg_locked | ~in_group);
  assign start_ok   = (opc_r == OP_WRR) ? wr_ok :
                      (opc_r == OP_WRITE_ANY_REGISTER_CMD) ? write_any_register_cmd_ok :
                      (fso_is_array(opc_r) & wel_r);

  assign status_one_volatile = {lock_r, 1'b0, tb_r, bp_r, wel_r, busy};
  assign status_two          = {1'b0, eerr_r, perr_r, 3'h0,
                                erase_suspended, 1'b0};
  assign block_protect       = bp_r;
  assign protect_from_top    = ~tb_r;

  always_comb
  begin
    unique case (link.rx_byte)
      OP_RD_SR1, OP_RD_SR2, OP_READ_ANY_REGISTER_CMD, OP_EPS, OP_CLEAR_STATUS_CMD,
      OP_READ_CONFIG_ONE_CMD, OP_READ_CONFIG_TWO_CMD, OP_READ_CONFIG_THREE_CMD, OP_RESET_ARM_CMD, OP_RST:
        busy_ok = 1'b1;
      default:
        busy_ok = 1'b0;
    endcase
  end

  // Frame decode; the command itself acts when chip select rises.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r     <= ST_IDLE;
      opc_r       <= 8'h00;
      addr_r      <= 24'h00_0000;
      addr_cnt_r  <= 2'h0;
      data_r      <= 8'h00;
      have_data_r <= 1'b0;
      exec_ok_r   <= 1'b0;
    end
    else if (link.frame_start)
    begin
      state_r     <= ST_OP;
      have_data_r <= 1'b0;
      exec_ok_r   <= 1'b0;
      addr_cnt_r  <= 2'h0;
    end
    else if (link.frame_end)
    begin
      state_r   <= ST_IDLE;
      exec_ok_r <= 1'b0;
    end
    else if (link.byte_valid)
    begin
      unique case (state_r)
        ST_OP:
        begin
          opc_r     <= link.rx_byte;
          exec_ok_r <= ~busy | busy_ok;
          if (busy && !busy_ok)
            state_r <= ST_SKIP;
          else if (link.rx_byte == OP_RD_SR1 ||
                   link.rx_byte == OP_RD_SR2)
            state_r <= ST_READ;
          else if (link.rx_byte == OP_WRR)
            state_r <= ST_DATA;
          else if (link.rx_byte == OP_WRITE_ANY_REGISTER_CMD)
            state_r <= ST_ADDR;
          else
            state_r <= ST_SKIP;
        end
        ST_ADDR:
        begin
          addr_r     <= {addr_r[15:0], link.rx_byte};
          addr_cnt_r <= addr_cnt_r + 2'h1;
          if (addr_cnt_r == 2'(ADDR_BYTES - 1))
            state_r <= ST_DATA;
        end
        ST_DATA:
        begin
          data_r      <= link.rx_byte;
          have_data_r <= 1'b1;
          state_r     <= ST_SKIP;
        end
        ST_IDLE, ST_READ, ST_SKIP:
          state_r <= state_r;
      endcase
    end
  end

  // Status reads repeat the live value for as long as the clock runs.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      link.tx_byte <= 8'h00;
      link.tx_en   <= 1'b0;
    end
    else
    begin
      link.tx_en   <= (state_r == ST_READ);
      link.tx_byte <= (opc_r == OP_RD_SR2) ? status_two
                                           : status_one_volatile;
    end
  end

  // Reset load is taken one clock after release, never from a port.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      load_r     <= 1'b1;
      armed_r    <= 1'b0;
      soft_reset <= 1'b0;
    end
    else
    begin
      soft_reset <= 1'b0;
      load_r     <= 1'b0;
      if (exec)
      begin
        armed_r <= (opc_r == OP_RESET_ARM_CMD);
        if (armed_r && opc_r == OP_RST)
        begin
          load_r     <= 1'b1;
          soft_reset <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lock_r <= 1'b0;
      tb_r   <= 1'b0;
      bp_r   <= 3'h0;
    end
    else if (load_r)
    begin
      lock_r <= nv_status_one[SR1_LOCK];
      tb_r   <= nv_status_one[SR1_TB];
      bp_r   <= nv_status_one[SR1_BP_HI:SR1_BP_LO];
    end
    else if (exec && start_ok &&
             (opc_r == OP_WRR ||
              (opc_r == OP_WRITE_ANY_REGISTER_CMD && addr_r == ADDR_STATUS_ONE_VOLATILE)))
    begin
      lock_r <= data_r[SR1_LOCK];
      tb_r   <= data_r[SR1_TB];
      bp_r   <= data_r[SR1_BP_HI:SR1_BP_LO];
    end
    else if (nv_update)
    begin
      lock_r <= nv_status_one[SR1_LOCK];
      tb_r   <= nv_status_one[SR1_TB];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wel_r <= 1'b0;
    else if (load_r)
      wel_r <= nv_status_one[SR1_WEL];
    else if (exec && opc_r == OP_WRITE_ENABLE_CMD)
      wel_r <= 1'b1;
    else if (exec && (opc_r == OP_WRITE_DISABLE_CMD || opc_r == OP_CLEAR_STATUS_CMD))
      wel_r <= 1'b0;
    else if (running_r && op_done && !op_fail)
      wel_r <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      running_r  <= 1'b0;
      erase_op_r <= 1'b0;
      op_start   <= 1'b0;
      op_code    <= 8'h00;
    end
    else
    begin
      op_start <= 1'b0;
      if (soft_reset)
        running_r <= 1'b0;
      else if (exec && start_ok)
      begin
        running_r  <= 1'b1;
        erase_op_r <= fso_is_erase(opc_r);
        op_start   <= 1'b1;
        op_code    <= opc_r;
      end
      else if (op_done || op_fail)
        running_r <= 1'b0;
    end
  end

  // A failure in the same cycle as clear-status survives it.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      perr_r <= 1'b0;
      eerr_r <= 1'b0;
    end
    else if (running_r && op_fail)
    begin
      eerr_r <= eerr_r | erase_op_r;
      perr_r <= perr_r | ~erase_op_r;
    end
    else if (soft_reset || (exec && opc_r == OP_CLEAR_STATUS_CMD))
    begin
      perr_r <= 1'b0;
      eerr_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      suspend_req <= 1'b0;
    else
      suspend_req <= exec && opc_r == OP_EPS && array_op_active;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_write_enable_cmd_sets_wel: assert property (
    exec && opc_r == OP_WRITE_ENABLE_CMD && !load_r |=> wel_r)
    else $error("Write enable did not set the latch.");

  a_write_disable_cmd_clears_wel: assert property (
    exec && opc_r == OP_WRITE_DISABLE_CMD && !load_r |=> !wel_r)
    else $error("Write disable did not clear the latch.");

  a_locked_no_wrr: assert property (
    exec && opc_r == OP_WRR && reg_locked |=> !op_start && $stable(lock_r))
    else $error("Register write ran while locked.");

  a_start_needs_wel: assert property (
    $rose(op_start) |-> $past(wel_r))
    else $error("Operation started without write enable.");

  a_done_clears_wel: assert property (
    running_r && op_done && !op_fail && !load_r && !exec |=> !wel_r)
    else $error("Latch not cleared after success.");

  a_fail_keeps_busy: assert property (
    running_r && op_fail ##1 !(exec && opc_r == OP_CLEAR_STATUS_CMD) && !soft_reset
    |=> status_one_volatile[SR1_BUSY] [*2])
    else $error("Busy dropped while an error flag was set.");

  a_busy_gates_cmd: assert property (
    state_r == ST_OP && link.byte_valid && busy && !busy_ok
    && !link.frame_start && !link.frame_end |=> !exec_ok_r)
    else $error("Command accepted while busy.");

  a_eps_needs_array: assert property (
    suspend_req |-> $past(array_op_active, 1))
    else $error("Suspend issued with no array operation.");

  a_reset_loads_wel: assert property (
    load_r |=> wel_r == $past(nv_status_one[SR1_WEL]))
    else $error("Latch not loaded from its default.");

  a_quad_unlocks: assert property (
    quad_protocol_mode || quad_data_mode |-> !reg_locked)
    else $error("Quad mode left registers locked.");

  a_wrr_keeps_wel: assert property (
    $rose(op_start) && op_code == OP_WRR |-> wel_r == $past(wel_r))
    else $error("Register write changed the latch.");

  c_write_enable_cmd: cover property (exec && opc_r == OP_WRITE_ENABLE_CMD);
  c_wrr_start: cover property (op_start && op_code == OP_WRR);
  c_status_read: cover property (spi_so_oe ##2 link.frame_end);
  c_suspend: cover property (suspend_req);
endmodule : fso_status_one

// File: src/fso_sync.sv
// Purpose: Two-stage synchroniser for pin levels.
// Assumes: Inputs are asynchronous to clk.
// Notes:   The first stage feeds only the second.
`timescale 1ns/10ps
module fso_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : fso_sync

// File: tb/flash_status_one_protect_logic_test.sv
// Purpose: Self-checking bench for the status one block.
// Assumes: The bench plays the embedded engine and the non-volatile store.
// Notes:   Expected bits come from a small integer model of the register.
`timescale 1ns/10ps
module flash_status_one_protect_logic_test;
  import fso_pkg::*;
  logic        clk, rst, sclk, cs_n, si, so, wp_n, nv_update, qpm, qdm;
  logic        arr_act, ers_susp, op_done, op_fail, op_start, susp_req;
  logic        soft_rst, reg_locked, from_top, so_oe;
  logic [7:0]  nv_sr1, op_code, sr1, sr2, rd;
  logic [2:0]  bp;
  logic [31:0] seed;
  int          err_total, n_checks, n_start, n_susp, n_srst, cyc;
  int          e_start, e_susp, e_srst;
  int          m_lock, m_ref, m_bp, m_wel, m_busy, m_perr, m_eerr;

  fso_status_one i_dut (.clk(clk), .rst(rst), .spi_sclk(sclk),
    .spi_cs_n(cs_n), .spi_si(si), .wp_n(wp_n), .spi_so(so),
    .spi_so_oe(so_oe),
    .nv_status_one(nv_sr1), .nv_update(nv_update),
    .quad_protocol_mode(qpm), .quad_data_mode(qdm),
    .array_op_active(arr_act), .erase_suspended(ers_susp),
    .op_done(op_done), .op_fail(op_fail), .op_start(op_start),
    .op_code(op_code), .suspend_req(susp_req), .soft_reset(soft_rst),
    .status_one_volatile(sr1), .status_two(sr2), .reg_locked(reg_locked),
    .block_protect(bp), .protect_from_top(from_top));
  fso_host_model i_host (.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_si(si),
    .spi_so(so));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [7:0] m_sr1();
    m_sr1 = {m_lock[0], 1'b0, m_ref[0], m_bp[2:0], m_wel[0], m_busy[0]};
  endfunction : m_sr1

  task automatic finish_test();
    if (err_total == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_count(input int got, input int exp);
    n_checks++;
    if (got != exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_count

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Frames start just after a clock edge so no link edge meets a clk edge.
  task automatic send(input int n, input logic [39:0] tx);
    tick(1);
    i_host.xfer(n, tx, rd);
  endtask : send

  task automatic reload();
    m_lock = nv_sr1[7];
    m_ref  = nv_sr1[5];
    m_bp   = nv_sr1[4:2];
    m_wel  = nv_sr1[1];
    m_busy = 0;
    m_perr = 0;
    m_eerr = 0;
  endtask : reload

  task automatic rd_chk();
    send(2, {OP_RD_SR1, 32'h0000_0000});
    chk_byte(rd, m_sr1());
    chk_byte(sr1, m_sr1());
    chk_byte({4'h0, from_top, bp},
             {4'h0, ~m_ref[0], m_bp[2:0]});
    chk_byte({7'h00, so_oe}, 8'h00);
  endtask : rd_chk

  task automatic rd2_chk();
    send(2, {OP_RD_SR2, 32'h0000_0000});
    chk_byte(rd, {1'b0, m_eerr[0], m_perr[0], 3'b000,
                  ers_susp, 1'b0});
    chk_byte(sr2, {1'b0, m_eerr[0], m_perr[0], 3'b000,
                   ers_susp, 1'b0});
  endtask : rd2_chk

  task automatic engine(input logic ok);
    tick(1);
    op_done = ok;
    op_fail = ~ok;
    tick(1);
    op_done = 1'b0;
    op_fail = 1'b0;
    tick(3);
  endtask : engine

  // A taken write also runs a refused disable while busy, then completes.
  task automatic wr_reg(input logic [7:0] op, input logic [7:0] d,
                        input logic take);
    if (op == OP_WRR)
      send(2, {OP_WRR, d, 24'h00_0000});
    else
      send(5, {OP_WRITE_ANY_REGISTER_CMD, ADDR_STATUS_ONE_VOLATILE, d});
    if (take)
    begin
      m_lock = d[7];
      m_ref  = d[5];
      m_bp   = d[4:2];
      m_busy = 1;
      e_start++;
      chk_byte(op_code, op);
    end
    chk_count(n_start, e_start);
    rd_chk();
    if (take)
    begin
      send(1, {OP_WRITE_DISABLE_CMD, 32'h0000_0000});
      rd_chk();
      engine(1'b1);
      m_busy = 0;
      m_wel  = 0;
      rd_chk();
    end
  endtask : wr_reg

  always @(posedge clk)
  begin
    cyc++;
    if (op_start === 1'b1)
      n_start++;
    if (susp_req === 1'b1)
      n_susp++;
    if (soft_rst === 1'b1)
      n_srst++;
    // The whole run needs about 12000 cycles.
    if (cyc == 40000)
    begin
      err_total++;
      finish_test();
    end
  end

  initial
  begin
    {rst, wp_n, nv_update, qpm, qdm} = 5'b11000;
    {arr_act, ers_susp, op_done, op_fail} = 4'b0000;
    seed = lfsr(32'h0000_e126);
    nv_sr1 = seed[7:0] & 8'hbe;
    tick(3);
    rst = 1'b0;
    tick(6);
    reload();
    rd_chk();
    send(1, {OP_WRITE_DISABLE_CMD, 32'h0000_0000});
    m_wel = 0;
    rd_chk();
    wr_reg(OP_WRR, 8'h1c, 1'b0);
    send(1, {OP_WRITE_ENABLE_CMD, 32'h0000_0000});
    m_wel = 1;
    rd_chk();
    seed = lfsr(seed);
    wr_reg(OP_WRR, (seed[7:0] & 8'h7f) | 8'h01, 1'b1);
    send(1, {OP_WRITE_ENABLE_CMD, 32'h0000_0000});
    m_wel = 1;
    wr_reg(OP_WRR, 8'h80 | (seed[15:8] & 8'h3c), 1'b1);
    wp_n = 1'b0;
    tick(4);
    chk_byte({7'h00, reg_locked}, 8'h01);
    send(1, {OP_WRITE_ENABLE_CMD, 32'h0000_0000});
    m_wel = 1;
    rd_chk();
    wr_reg(OP_WRITE_ANY_REGISTER_CMD, 8'h00, 1'b0);
    wr_reg(OP_WRR, 8'h00, 1'b0);
    for (int m = 0; m < 2; m++)
    begin
      {qpm, qdm} = (m == 0) ? 2'b01 : 2'b10;
      tick(2);
      chk_byte({7'h00, reg_locked}, 8'h00);
    end
    wr_reg(OP_WRITE_ANY_REGISTER_CMD, 8'h14, 1'b1);
    {qpm, qdm} = 2'b00;
    tick(2);
    send(1, {OP_WRITE_ENABLE_CMD, 32'h0000_0000});
    m_wel = 1;
    wr_reg(OP_WRR, 8'h28, 1'b1);
    seed = lfsr(seed);
    nv_sr1 = seed[7:0] & 8'hbe;
    nv_update = 1'b1;
    tick(1);
    nv_update = 1'b0;
    tick(2);
    m_lock = nv_sr1[7];
    m_ref  = nv_sr1[5];
    rd_chk();
    send(1, {OP_WRITE_ENABLE_CMD, 32'h0000_0000});
    m_wel = 1;
    send(5, {OP_PP, 32'h0000_10a5});
    m_busy = 1;
    e_start++;
    chk_count(n_start, e_start);
    chk_byte(op_code, OP_PP);
    engine(1'b0);
    m_perr = 1;
    rd2_chk();
    rd_chk();
    send(1, {OP_CLEAR_STATUS_CMD, 32'h0000_0000});
    {m_perr, m_busy, m_wel} = 0;
    rd2_chk();
    rd_chk();
    send(1, {OP_WRITE_ENABLE_CMD, 32'h0000_0000});
    m_wel = 1;
    arr_act = 1'b1;
    send(5, {OP_P4E, 32'h0010_0000});
    m_busy = 1;
    e_start++;
    chk_byte(op_code, OP_P4E);
    send(1, {OP_EPS, 32'h0000_0000});
    e_susp++;
    chk_count(n_susp, e_susp);
    ers_susp = 1'b1;
    tick(2);
    rd2_chk();
    engine(1'b0);
    m_eerr = 1;
    arr_act = 1'b0;
    send(1, {OP_EPS, 32'h0000_0000});
    chk_count(n_susp, e_susp);
    rd2_chk();
    ers_susp = 1'b0;
    send(1, {OP_RESET_ARM_CMD, 32'h0000_0000});
    send(1, {OP_RST, 32'h0000_0000});
    e_srst++;
    reload();
    chk_count(n_srst, e_srst);
    rd_chk();
    rd2_chk();
    chk_count(n_start, e_start);
    finish_test();
  end
endmodule : flash_status_one_protect_logic_test

// File: tb/fso_host_model.sv
// Purpose: Host serial controller model that issues mode 0 frames.
// Assumes: Link clock period 125 ns, clock held low between frames.
// Notes:   The data line shows the inverse of its last bit when released.
`timescale 1ns/10ps
module fso_host_model (
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_si,
  input  wire logic spi_so
);
  initial
  begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_si   = 1'b0;
  end

  // One frame, MSB first; rx keeps the last eight bits seen on the reply.
  task automatic xfer(input int nbytes, input logic [39:0] tx,
                      output logic [7:0] rx);
    rx = 8'h00;
    spi_cs_n = 1'b0;
    for (int i = 0; i < 8 * nbytes; i++)
    begin
      spi_si = tx[39 - i];
      #62.5 spi_sclk = 1'b1;
      rx = {rx[6:0], spi_so};
      #62.5 spi_sclk = 1'b0;
    end
    #62.5 spi_cs_n = 1'b1;
    // A stale bit must never pass for a driven one.
    spi_si = ~spi_si;
    #250;
  endtask : xfer
endmodule : fso_host_model
